// File: logic/lecnt_link_error_counters.sv
`timescale 1ns/1ps
`include "lecnt_regs.svh"

module lecnt_link_error_counters #(
  parameter int SLOTS = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // mode configuration
  input wire logic t1Mode,
  input wire logic esfLinks,
  input wire logic zeroSubstEnable,
  // receive events
  input wire lecnt_pkg::lecnt_events_t rxEvents,
  // microport
  input wire logic [3:0] page,
  input wire logic [4:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData_q,
  // interrupt pulses, bit positions follow the mask words
  output logic [7:0] eventIrq_q,
  output logic [7:0] overflowIrq_q,
  // transmit error injection
  output lecnt_pkg::lecnt_inject_t inject_q,
  // timeslot control lookup for the data path
  input wire logic [4:0] slotSel,
  output logic [7:0] slotCtrl_q
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // increment with wrap at a given maximum
  function automatic logic [15:0] wrapInc(input logic [15:0] v, input logic [15:0] max);
    wrapInc = (v == max) ? 16'h0000 : v + 16'h0001;
  endfunction

  // true when an increment wraps the count
  function automatic logic wraps(input logic inc, input logic [15:0] v, input logic [15:0] max);
    wraps = inc && (v == max);
  endfunction

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  lecnt_pkg::lecnt_sel_t sel; // which register group is addressed
  logic [4:0] slotIdx; // timeslot addressed on the slot pages
  logic slotValid; // slot exists in the current mode
  logic wrCnt; // write to counter page
  logic wrMst; // write to master page

  // map page to register group
  always_comb begin
    case (page)
      `LECNT_PAGE_COUNT: sel = lecnt_pkg::LECNT_SEL_COUNT;
      `LECNT_PAGE_MASTER: sel = lecnt_pkg::LECNT_SEL_MASTER;
      `LECNT_PAGE_SLOT_A, `LECNT_PAGE_SLOT_B: sel = lecnt_pkg::LECNT_SEL_SLOT;
      default: sel = lecnt_pkg::LECNT_SEL_NONE;
    endcase
  end

  // slot pages: page A holds 0..15, page B holds 16..31
  assign slotIdx = {page == `LECNT_PAGE_SLOT_B, addr[3:0]};
  assign slotValid = (sel == lecnt_pkg::LECNT_SEL_SLOT) && !addr[4] &&
                     (!t1Mode || ({1'b0, slotIdx} < `LECNT_T1_SLOTS));
  assign wrCnt = wrStb && (sel == lecnt_pkg::LECNT_SEL_COUNT);
  assign wrMst = wrStb && (sel == lecnt_pkg::LECNT_SEL_MASTER);

  // ---------------------------------------------------------------
  // master control registers
  // ---------------------------------------------------------------
  logic [7:0] injectCtrl_q; // error injection control
  logic [7:0] resetCtrl_q; // reset control, counter clear bit
  logic [7:0] maskOne_q; // event interrupt enables
  logic [7:0] maskTwo_q; // overflow interrupt enables
  logic counter_clear; // counters held at zero

  // host writes to master page
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      injectCtrl_q <= `LECNT_REG_RESET;
      resetCtrl_q <= `LECNT_REG_RESET;
      maskOne_q <= `LECNT_REG_RESET;
      maskTwo_q <= `LECNT_REG_RESET;
    end else if (wrMst) begin
      case (addr)
        `LECNT_OFS_INJECT: injectCtrl_q <= wrData;
        `LECNT_OFS_RESET_CTRL: resetCtrl_q <= wrData;
        `LECNT_OFS_MASK_ONE: maskOne_q <= wrData;
        `LECNT_OFS_MASK_TWO: maskTwo_q <= wrData;
        default: ;
      endcase
    end
  end
  assign counter_clear = resetCtrl_q[`LECNT_BIT_COUNTER_CLEAR];

  // ---------------------------------------------------------------
  // increment qualifiers
  // ---------------------------------------------------------------
  logic [1:0] crcBudget_q; // CRC-4 increments left this multiframe
  logic [1:0] ebitBudget_q; // far-end increments left this multiframe
  logic crcInc; // CRC counter advances
  logic bpvInc; // violation counter advances
  logic fasInc; // alignment error counter advances
  logic ebitInc; // far-end counter advances
  logic [15:0] crcMax; // CRC counter wrap point by mode

  assign crcInc = !counter_clear && !(wrCnt && (addr | 5'h01) == `LECNT_OFS_CRC_HI) &&
                  (t1Mode ? (esfLinks && rxEvents.crcErr)
                          : (rxEvents.crcErr && crcBudget_q != 2'h0));
  assign bpvInc = !counter_clear && !(wrCnt && (addr | 5'h01) == `LECNT_OFS_BPV_HI) &&
                  rxEvents.violationErr;
  assign fasInc = !counter_clear && !(wrCnt && addr == `LECNT_OFS_FAS_ERR) &&
                  !t1Mode && rxEvents.alignErr;
  assign ebitInc = !counter_clear && !(wrCnt && (addr | 5'h01) == `LECNT_OFS_EBIT_HI) &&
                   !t1Mode && rxEvents.farEndBlockErr && ebitBudget_q != 2'h0;
  assign crcMax = t1Mode ? `LECNT_MAX16 : `LECNT_MAX10;

  // per-multiframe budgets refill at each multiframe boundary
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crcBudget_q <= `LECNT_MF_BUDGET;
      ebitBudget_q <= `LECNT_MF_BUDGET;
    end else begin
      if (rxEvents.crcMultiframe) begin
        crcBudget_q <= `LECNT_MF_BUDGET;
        ebitBudget_q <= `LECNT_MF_BUDGET;
      end else begin
        if (crcInc && !t1Mode) begin
          crcBudget_q <= crcBudget_q - 2'h1;
        end
        if (ebitInc) begin
          ebitBudget_q <= ebitBudget_q - 2'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // error counters
  // ---------------------------------------------------------------
  logic [15:0] crcCnt_q; // CRC-6 or CRC-4 errors
  logic [15:0] bpvCnt_q; // line code violations
  logic [15:0] ebitCnt_q; // far-end block errors, 10 bits used
  logic [7:0] fasCnt_q; // errored alignment words
  logic [7:0] prbsCnt_q; // test-sequence errors
  logic [7:0] mfCnt_q; // received CRC multiframes

  // CRC counter: host load per byte, else wrap-around count
  always_ff @(posedge clk) begin
    if (!rst_b || counter_clear) begin
      crcCnt_q <= 16'h0000;
    end else if (wrCnt && addr == `LECNT_OFS_CRC_LO) begin
      crcCnt_q[7:0] <= wrData;
    end else if (wrCnt && addr == `LECNT_OFS_CRC_HI) begin
      crcCnt_q[15:8] <= t1Mode ? wrData : {6'h00, wrData[1:0]};
    end else if (crcInc) begin
      crcCnt_q <= wrapInc(crcCnt_q, crcMax);
    end
  end

  // violation counter: host loads low or high byte alone, in either order
  always_ff @(posedge clk) begin
    if (!rst_b || counter_clear) begin
      bpvCnt_q <= 16'h0000;
    end else if (wrCnt && addr == `LECNT_OFS_BPV_LO) begin
      bpvCnt_q[7:0] <= wrData;
    end else if (wrCnt && addr == `LECNT_OFS_BPV_HI) begin
      bpvCnt_q[15:8] <= wrData;
    end else if (bpvInc) begin
      bpvCnt_q <= wrapInc(bpvCnt_q, `LECNT_MAX16);
    end
  end

  // far-end block error counter, ten bits over two addresses
  always_ff @(posedge clk) begin
    if (!rst_b || counter_clear) begin
      ebitCnt_q <= 16'h0000;
    end else if (wrCnt && addr == `LECNT_OFS_EBIT_LO) begin
      ebitCnt_q[7:0] <= wrData;
    end else if (wrCnt && addr == `LECNT_OFS_EBIT_HI) begin
      ebitCnt_q[15:8] <= {6'h00, wrData[1:0]};
    end else if (ebitInc) begin
      ebitCnt_q <= wrapInc(ebitCnt_q, `LECNT_MAX10);
    end
  end

  // errored alignment word counter
  always_ff @(posedge clk) begin
    if (!rst_b || counter_clear) begin
      fasCnt_q <= 8'h00;
    end else if (wrCnt && addr == `LECNT_OFS_FAS_ERR) begin
      fasCnt_q <= wrData;
    end else if (fasInc) begin
      fasCnt_q <= fasCnt_q + 8'h01;
    end
  end

  // test-sequence error counter
  always_ff @(posedge clk) begin
    if (!rst_b || counter_clear) begin
      prbsCnt_q <= 8'h00;
    end else if (wrCnt && addr == `LECNT_OFS_PRBS_ERR) begin
      prbsCnt_q <= wrData;
    end else if (rxEvents.prbsErr) begin
      prbsCnt_q <= prbsCnt_q + 8'h01;
    end
  end

  // multiframe counter: cleared by error-count write, loadable
  always_ff @(posedge clk) begin
    if (!rst_b || counter_clear) begin
      mfCnt_q <= 8'h00;
    end else if (wrCnt && addr == `LECNT_OFS_PRBS_ERR) begin
      mfCnt_q <= 8'h00;
    end else if (wrCnt && addr == `LECNT_OFS_PRBS_MF) begin
      mfCnt_q <= wrData;
    end else if (rxEvents.crcMultiframe) begin
      mfCnt_q <= mfCnt_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // overflow detection
  // ---------------------------------------------------------------
  logic [7:0] ovfNow; // overflows this cycle, latch bit order
  logic ovfRead; // host reads the overflow latch
  logic [7:0] ovfLatch_q; // sticky overflow bits

  // wraps count only when that counter itself advances, not held or loaded
  always_comb begin
    ovfNow = 8'h00;
    ovfNow[`LECNT_OV_PRBS] = !counter_clear && !(wrCnt && addr == `LECNT_OFS_PRBS_ERR) &&
                             rxEvents.prbsErr && prbsCnt_q == 8'hFF;
    ovfNow[`LECNT_OV_FAS] = fasInc && fasCnt_q == 8'hFF;
    ovfNow[`LECNT_OV_EBIT] = wraps(ebitInc, ebitCnt_q, `LECNT_MAX10);
    ovfNow[`LECNT_OV_BPV] = wraps(bpvInc, bpvCnt_q, `LECNT_MAX16);
    ovfNow[`LECNT_OV_CRC] = wraps(crcInc, crcCnt_q, crcMax);
  end
  assign ovfRead = rdStb && sel == lecnt_pkg::LECNT_SEL_COUNT && addr == `LECNT_OFS_OVF_LATCH;

  // read clears, a new overflow in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ovfLatch_q <= 8'h00;
    end else begin
      ovfLatch_q <= (ovfRead ? 8'h00 : ovfLatch_q) | ovfNow;
    end
  end

  // ---------------------------------------------------------------
  // interrupt pulses
  // ---------------------------------------------------------------
  // event pulses fire when the CRC, violation, alignment or far-end counter advances, not on host loads
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      eventIrq_q <= 8'h00;
      overflowIrq_q <= 8'h00;
    end else begin
      eventIrq_q <= 8'h00;
      eventIrq_q[`LECNT_M1_CRC] <= crcInc && maskOne_q[`LECNT_M1_CRC];
      eventIrq_q[`LECNT_M1_BPV] <= bpvInc && maskOne_q[`LECNT_M1_BPV];
      eventIrq_q[`LECNT_M1_FAS] <= fasInc && maskOne_q[`LECNT_M1_FAS];
      eventIrq_q[`LECNT_M1_EBIT] <= ebitInc && maskOne_q[`LECNT_M1_EBIT];
      overflowIrq_q <= 8'h00;
      overflowIrq_q[`LECNT_M2_CRC] <= ovfNow[`LECNT_OV_CRC] && maskTwo_q[`LECNT_M2_CRC];
      overflowIrq_q[`LECNT_M2_BPV] <= ovfNow[`LECNT_OV_BPV] && maskTwo_q[`LECNT_M2_BPV];
      overflowIrq_q[`LECNT_M2_PRBS] <= ovfNow[`LECNT_OV_PRBS] && maskTwo_q[`LECNT_M2_PRBS];
      overflowIrq_q[`LECNT_M2_FAS] <= ovfNow[`LECNT_OV_FAS] && maskTwo_q[`LECNT_M2_FAS];
      overflowIrq_q[`LECNT_M2_EBIT] <= ovfNow[`LECNT_OV_EBIT] && maskTwo_q[`LECNT_M2_EBIT];
    end
  end

  // ---------------------------------------------------------------
  // error injection outputs
  // ---------------------------------------------------------------
  // bit 0 violation, 1 checksum, 2 framing/alignment, 3 signaling/non-alignment,
  // 4 payload, 5 signal loss; same bits serve both modes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      inject_q <= '0;
    end else begin
      inject_q.injectViolation <= injectCtrl_q[0];
      inject_q.injectChecksumError <= injectCtrl_q[1];
      inject_q.injectFramingError <= injectCtrl_q[2];
      inject_q.injectSignalingOrNonAlignError <= injectCtrl_q[3];
      inject_q.injectPayloadError <= injectCtrl_q[4];
      inject_q.injectSignalLoss <= injectCtrl_q[5];
      // signal loss suppresses B8ZS or HDB3 substitution
      inject_q.zeroSubstAllowed <= zeroSubstEnable && !injectCtrl_q[5];
    end
  end

  // ---------------------------------------------------------------
  // timeslot control words
  // ---------------------------------------------------------------
  logic [7:0] slotMem_q [SLOTS]; // one control word per timeslot
  // host writes, clear channel bit stored as zero by writes made in E1
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < SLOTS; i++) begin
        slotMem_q[i] <= `LECNT_REG_RESET;
      end
    end else if (wrStb && slotValid) begin
      slotMem_q[slotIdx] <= {wrData[7:1], wrData[0] && t1Mode};
    end
  end

  // lookup for the data path, word n steers tx slot and rx channel n
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slotCtrl_q <= 8'h00;
    end else if (t1Mode && {1'b0, slotSel} >= `LECNT_T1_SLOTS) begin
      slotCtrl_q <= 8'h00;
    end else begin
      slotCtrl_q <= slotMem_q[slotSel];
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [7:0] rdMux; // selected register value
  // unmapped locations read zero
  always_comb begin
    rdMux = 8'h00;
    case (sel)
      lecnt_pkg::LECNT_SEL_COUNT: begin
        case (addr)
          `LECNT_OFS_PRBS_ERR: rdMux = prbsCnt_q;
          `LECNT_OFS_PRBS_MF: rdMux = mfCnt_q;
          `LECNT_OFS_FAS_ERR: rdMux = fasCnt_q;
          `LECNT_OFS_EBIT_LO: rdMux = ebitCnt_q[7:0];
          `LECNT_OFS_EBIT_HI: rdMux = ebitCnt_q[15:8];
          `LECNT_OFS_BPV_LO: rdMux = bpvCnt_q[7:0];
          `LECNT_OFS_BPV_HI: rdMux = bpvCnt_q[15:8];
          `LECNT_OFS_CRC_LO: rdMux = crcCnt_q[7:0];
          `LECNT_OFS_CRC_HI: rdMux = crcCnt_q[15:8];
          `LECNT_OFS_OVF_LATCH: rdMux = ovfLatch_q;
          default: rdMux = 8'h00;
        endcase
      end
      lecnt_pkg::LECNT_SEL_MASTER: begin
        case (addr)
          `LECNT_OFS_INJECT: rdMux = injectCtrl_q;
          `LECNT_OFS_RESET_CTRL: rdMux = resetCtrl_q;
          `LECNT_OFS_MASK_ONE: rdMux = maskOne_q;
          `LECNT_OFS_MASK_TWO: rdMux = maskTwo_q;
          default: rdMux = 8'h00;
        endcase
      end
      lecnt_pkg::LECNT_SEL_SLOT: begin
        rdMux = slotValid ? slotMem_q[slotIdx] : 8'h00;
      end
      default: rdMux = 8'h00;
    endcase
  end

  // read data captured on the read strobe and held
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdData_q <= 8'h00;
    end else if (rdStb) begin
      rdData_q <= rdMux;
    end
  end

endmodule // lecnt_link_error_counters

// File: logic/lecnt_regs.svh
`ifndef LECNT_REGS_SVH
`define LECNT_REGS_SVH

// ---------------------------------------------------------------
// pages
// ---------------------------------------------------------------
`define LECNT_PAGE_MASTER 4'h1
`define LECNT_PAGE_COUNT 4'h4
`define LECNT_PAGE_SLOT_A 4'hA
`define LECNT_PAGE_SLOT_B 4'hB

// ---------------------------------------------------------------
// counter page offsets
// ---------------------------------------------------------------
`define LECNT_OFS_PRBS_ERR 5'h10
`define LECNT_OFS_PRBS_MF 5'h11
`define LECNT_OFS_FAS_ERR 5'h13
`define LECNT_OFS_EBIT_LO 5'h14
`define LECNT_OFS_EBIT_HI 5'h15
`define LECNT_OFS_BPV_LO 5'h16
`define LECNT_OFS_BPV_HI 5'h17
`define LECNT_OFS_CRC_LO 5'h18
`define LECNT_OFS_CRC_HI 5'h19
`define LECNT_OFS_OVF_LATCH 5'h1F

// ---------------------------------------------------------------
// master control page offsets
// ---------------------------------------------------------------
`define LECNT_OFS_INJECT 5'h19
`define LECNT_OFS_RESET_CTRL 5'h1A
`define LECNT_OFS_MASK_ONE 5'h1C
`define LECNT_OFS_MASK_TWO 5'h1D

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LECNT_BIT_COUNTER_CLEAR 4
`define LECNT_M1_FAS 7
`define LECNT_M1_CRC 6
`define LECNT_M1_EBIT 5
`define LECNT_M1_BPV 3
`define LECNT_M2_PRBS 7
`define LECNT_M2_CRC 6
`define LECNT_M2_BPV 3
`define LECNT_M2_FAS 2
`define LECNT_M2_EBIT 0
`define LECNT_OV_PRBS 0
`define LECNT_OV_FAS 1
`define LECNT_OV_EBIT 2
`define LECNT_OV_BPV 3
`define LECNT_OV_CRC 4

// ---------------------------------------------------------------
// limits and reset values
// ---------------------------------------------------------------
`define LECNT_MAX16 16'hFFFF
`define LECNT_MAX10 16'h03FF
`define LECNT_MF_BUDGET 2'h2
`define LECNT_REG_RESET 8'h00
`define LECNT_T1_SLOTS 6'h18

`endif

// File: logic/lecnt_pkg.sv
package lecnt_pkg;

  // receive error events, one-cycle pulses from framing and decoding
  typedef struct packed {
    logic crcErr;
    logic violationErr;
    logic prbsErr;
    logic crcMultiframe;
    logic alignErr;
    logic farEndBlockErr;
  } lecnt_events_t;

  // transmit error injection controls
  typedef struct packed {
    logic injectViolation;
    logic injectChecksumError;
    logic injectFramingError;
    logic injectSignalingOrNonAlignError;
    logic injectPayloadError;
    logic injectSignalLoss;
    logic zeroSubstAllowed;
  } lecnt_inject_t;

  // decoded register selection
  typedef enum logic [2:0] {
    LECNT_SEL_NONE = 3'b000,
    LECNT_SEL_COUNT = 3'b001,
    LECNT_SEL_MASTER = 3'b010,
    LECNT_SEL_SLOT = 3'b011
  } lecnt_sel_t;

endpackage

// File: verification/lecnt_link_error_counters_assertions.sv
`timescale 1ns/1ps

module lecnt_link_error_counters_assertions #(
  parameter int SLOTS = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // mode and events
  input wire logic t1Mode,
  input wire logic esfLinks,
  input wire logic zeroSubstEnable,
  input wire lecnt_pkg::lecnt_events_t rxEvents,
  // microport
  input wire logic [3:0] page,
  input wire logic [4:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  input wire logic [7:0] rdData_q,
  // interrupts and controls
  input wire logic [7:0] eventIrq_q,
  input wire logic [7:0] overflowIrq_q,
  input wire lecnt_pkg::lecnt_inject_t inject_q,
  input wire logic [4:0] slotSel,
  input wire logic [7:0] slotCtrl_q
);
  // ---------------------------------------------------------------
  // checks, all on the one clock
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_violation_event_cause: assert property (eventIrq_q[3] |-> $past(rxEvents.violationErr))
    else $error("violation event pulse without a violation");
  a_crc_event_cause: assert property (eventIrq_q[6] |->
    $past(rxEvents.crcErr) && (!$past(t1Mode) || $past(esfLinks)))
    else $error("crc event pulse without a qualified crc error");
  a_align_e1_only: assert property (eventIrq_q[7] |-> $past(rxEvents.alignErr) && !$past(t1Mode))
    else $error("alignment event outside e1 or without cause");
  a_far_end_e1_only: assert property ((eventIrq_q[5] || overflowIrq_q[0]) |->
    $past(rxEvents.farEndBlockErr) && !$past(t1Mode))
    else $error("far-end pulse outside e1 or without cause");
  a_unused_event_quiet: assert property ((eventIrq_q & 8'h17) == 8'h00)
    else $error("event pulse on an unassigned bit");
  a_prbs_overflow_cause: assert property (overflowIrq_q[7] |-> $past(rxEvents.prbsErr))
    else $error("test-sequence overflow without an error");
  a_violation_wrap_single: assert property (overflowIrq_q[3] |=> (!overflowIrq_q[3]) [*2])
    else $error("violation overflow repeated too soon");
  a_loss_over_subst: assert property (inject_q.injectSignalLoss |-> !inject_q.zeroSubstAllowed)
    else $error("zero substitution allowed during signal loss");
  a_slot_t1_limit: assert property ($past(t1Mode) && ($past(slotSel) >= 5'h18) |->
    slotCtrl_q == 8'h00)
    else $error("nonzero control word beyond slot 23 in t1");
  a_read_data_stands: assert property (!$past(rdStb) |-> $stable(rdData_q))
    else $error("read data changed without a read strobe");
endmodule // lecnt_link_error_counters_assertions

bind lecnt_link_error_counters lecnt_link_error_counters_assertions #(.SLOTS(SLOTS)) chk_u (
  .clk(clk), .rst_b(rst_b), .t1Mode(t1Mode), .esfLinks(esfLinks),
  .zeroSubstEnable(zeroSubstEnable), .rxEvents(rxEvents), .page(page), .addr(addr),
  .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData_q(rdData_q),
  .eventIrq_q(eventIrq_q), .overflowIrq_q(overflowIrq_q), .inject_q(inject_q),
  .slotSel(slotSel), .slotCtrl_q(slotCtrl_q)
);

// File: verification/lecnt_host_model.sv
`timescale 1ns/1ps

module lecnt_host_model (
  // clock
  input wire logic clk,
  // microport toward the device
  output logic [3:0] page,
  output logic [4:0] addr,
  output logic [7:0] wrData,
  output logic wrStb,
  output logic rdStb,
  input wire logic [7:0] rdData_q
);
  // bus idle at time zero
  initial begin
    page = 4'h0;
    addr = 5'h00;
    wrData = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
  end

  // one strobed access, entered at a rising edge; released lines flip
  // so a stale value can never pass for a fresh one
  task automatic xfer(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d,
                      input logic w, output logic [7:0] q);
    page <= p;
    addr <= a;
    wrData <= d;
    wrStb <= w;
    rdStb <= !w;
    @(posedge clk);
    wrStb <= 1'b0;
    rdStb <= 1'b0;
    page <= ~p;
    addr <= ~a;
    wrData <= ~d;
    @(posedge clk);
    q = rdData_q;
  endtask

  // sixteen-bit preset, low byte strictly first
  task automatic wr16(input logic [3:0] p, input logic [4:0] a, input logic [15:0] d);
    logic [7:0] q;
    xfer(p, a, d[7:0], 1'b1, q);
    xfer(p, a + 5'h01, d[15:8], 1'b1, q);
  endtask
endmodule // lecnt_host_model

// File: verification/tb_lecnt_link_error_counters.sv
`timescale 1ns/1ps
`include "lecnt_regs.svh"

module tb_lecnt_link_error_counters;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk;
  logic rst_b;
  logic t1Mode;
  logic esfLinks;
  logic zeroSubstEnable;
  lecnt_pkg::lecnt_events_t rxEvents;
  logic [3:0] page;
  logic [4:0] addr;
  logic [7:0] wrData;
  logic wrStb;
  logic rdStb;
  logic [7:0] rdData_q;
  logic [7:0] eventIrq_q;
  logic [7:0] overflowIrq_q;
  lecnt_pkg::lecnt_inject_t inject_q;
  logic [4:0] slotSel;
  logic [7:0] slotCtrl_q;
  logic [7:0] evSeen; // event pulses seen after a fire
  logic [7:0] ovSeen; // overflow pulses seen after a fire
  int errCount = 0;
  int checkCount = 0;
  // short page names and event patterns
  localparam logic [3:0] pgM = `LECNT_PAGE_MASTER;
  localparam logic [3:0] pgC = `LECNT_PAGE_COUNT;
  localparam logic [5:0] evCrc = 6'h20;
  localparam logic [5:0] evBpv = 6'h10;
  localparam logic [5:0] evPrbs = 6'h08;
  localparam logic [5:0] evMf = 6'h04;
  localparam logic [5:0] evFas = 6'h02;
  localparam logic [5:0] evFeb = 6'h01;

  lecnt_link_error_counters #(.SLOTS(32)) dut_u (
    .clk(clk), .rst_b(rst_b), .t1Mode(t1Mode), .esfLinks(esfLinks),
    .zeroSubstEnable(zeroSubstEnable), .rxEvents(rxEvents), .page(page), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData_q(rdData_q),
    .eventIrq_q(eventIrq_q), .overflowIrq_q(overflowIrq_q), .inject_q(inject_q),
    .slotSel(slotSel), .slotCtrl_q(slotCtrl_q)
  );

  lecnt_host_model host_u (
    .clk(clk), .page(page), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData_q(rdData_q)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // verdict and end of run
  task automatic finishTest();
    if (errCount == 0 && checkCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare one byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      errCount++;
    end
  endtask

  // register write
  task automatic wr(input logic [3:0] p, input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    host_u.xfer(p, a, d, 1'b1, q);
  endtask

  // register read and compare
  task automatic rdchk(input logic [3:0] p, input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host_u.xfer(p, a, 8'h00, 1'b0, q);
    chk(q, exp);
  endtask

  // one-cycle receive event, pulses captured once settled
  task automatic fire(input logic [5:0] ev);
    rxEvents <= lecnt_pkg::lecnt_events_t'(ev);
    @(posedge clk);
    rxEvents <= '0;
    #1;
    evSeen = eventIrq_q;
    ovSeen = overflowIrq_q;
    @(posedge clk);
  endtask

  // hang guard
  initial begin
    #40000;
    errCount++;
    finishTest();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    t1Mode = 1'b0;
    esfLinks = 1'b0;
    zeroSubstEnable = 1'b1;
    rxEvents = '0;
    slotSel = 5'h00;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdchk(pgC, `LECNT_OFS_BPV_LO, 8'h00);
    rdchk(pgC, 5'h12, 8'h00);
    wr(pgM, `LECNT_OFS_MASK_ONE, 8'hFF);
    wr(pgM, `LECNT_OFS_MASK_TWO, 8'hFF);
    rdchk(pgM, `LECNT_OFS_MASK_TWO, 8'hFF);
    // multiframe counter: load, advance, clear by error write
    wr(pgC, `LECNT_OFS_PRBS_MF, 8'h33);
    fire(evMf);
    rdchk(pgC, `LECNT_OFS_PRBS_MF, 8'h34);
    wr(pgC, `LECNT_OFS_PRBS_ERR, 8'hFF);
    rdchk(pgC, `LECNT_OFS_PRBS_MF, 8'h00);
    fire(evPrbs);
    chk(ovSeen & 8'h80, 8'h80);
    rdchk(pgC, `LECNT_OFS_PRBS_ERR, 8'h00);
    // violation wrap in e1, latch read clears
    host_u.wr16(pgC, `LECNT_OFS_BPV_LO, 16'hFFFF);
    fire(evBpv);
    chk(evSeen & 8'h08, 8'h08);
    chk(ovSeen & 8'h08, 8'h08);
    rdchk(pgC, `LECNT_OFS_BPV_HI, 8'h00);
    rdchk(pgC, `LECNT_OFS_OVF_LATCH, 8'h09);
    rdchk(pgC, `LECNT_OFS_OVF_LATCH, 8'h00);
    // errored alignment word wrap
    wr(pgC, `LECNT_OFS_FAS_ERR, 8'hFF);
    fire(evFas);
    chk(evSeen & 8'h80, 8'h80);
    chk(ovSeen & 8'h04, 8'h04);
    rdchk(pgC, `LECNT_OFS_FAS_ERR, 8'h00);
    // at most two far-end and crc-4 counts per multiframe
    fire(evMf);
    repeat (3) fire(evCrc | evFeb);
    chk(evSeen & 8'h60, 8'h00);
    rdchk(pgC, `LECNT_OFS_EBIT_LO, 8'h02);
    rdchk(pgC, `LECNT_OFS_CRC_LO, 8'h02);
    wr(pgC, `LECNT_OFS_EBIT_HI, 8'hFF);
    rdchk(pgC, `LECNT_OFS_EBIT_HI, 8'h03);
    host_u.wr16(pgC, `LECNT_OFS_EBIT_LO, 16'h03FF);
    fire(evMf);
    fire(evFeb);
    chk(evSeen & 8'h20, 8'h20);
    chk(ovSeen & 8'h01, 8'h01);
    host_u.wr16(pgC, `LECNT_OFS_CRC_LO, 16'h03FF);
    fire(evMf);
    fire(evCrc);
    chk(evSeen & 8'h40, 8'h40);
    chk(ovSeen & 8'h40, 8'h40);
    rdchk(pgC, `LECNT_OFS_CRC_HI, 8'h00);
    // t1: violations, counter clear, masking, crc-6 only with esf
    t1Mode <= 1'b1;
    fire(evBpv | evFas);
    chk(evSeen & 8'h88, 8'h08);
    rdchk(pgC, `LECNT_OFS_BPV_LO, 8'h01);
    rdchk(pgC, `LECNT_OFS_FAS_ERR, 8'h00);
    wr(pgM, `LECNT_OFS_RESET_CTRL, 8'h10);
    fire(evBpv);
    chk(evSeen, 8'h00);
    rdchk(pgC, `LECNT_OFS_BPV_LO, 8'h00);
    wr(pgM, `LECNT_OFS_RESET_CTRL, 8'h00);
    wr(pgM, `LECNT_OFS_MASK_ONE, 8'hF7);
    fire(evBpv);
    chk(evSeen & 8'h08, 8'h00);
    fire(evCrc);
    rdchk(pgC, `LECNT_OFS_CRC_LO, 8'h00);
    esfLinks <= 1'b1;
    repeat (3) fire(evCrc);
    chk(evSeen & 8'h40, 8'h40);
    rdchk(pgC, `LECNT_OFS_CRC_LO, 8'h03);
    host_u.wr16(pgC, `LECNT_OFS_CRC_LO, 16'h03FF);
    fire(evCrc);
    rdchk(pgC, `LECNT_OFS_CRC_HI, 8'h04);
    host_u.wr16(pgC, `LECNT_OFS_CRC_LO, 16'hFFFF);
    fire(evCrc);
    chk(ovSeen & 8'h40, 8'h40);
    rdchk(pgC, `LECNT_OFS_CRC_LO, 8'h00);
    // every injection bit in both modes
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 6; i++) begin
        wr(pgM, `LECNT_OFS_INJECT, 8'h01 << i);
        repeat (2) @(posedge clk);
        chk({1'b0, inject_q}, {1'b0, (7'h40 >> i) | {6'h00, i != 5}});
      end
      t1Mode <= 1'b0;
    end
    // timeslot words: t1 limit, layout, e1 clear channel
    t1Mode <= 1'b1;
    wr(`LECNT_PAGE_SLOT_A, 5'h03, 8'h81);
    wr(`LECNT_PAGE_SLOT_B, 5'h08, 8'h77);
    slotSel <= 5'h03;
    repeat (2) @(posedge clk);
    chk(slotCtrl_q, 8'h81);
    slotSel <= 5'h18;
    repeat (2) @(posedge clk);
    chk(slotCtrl_q, 8'h00);
    t1Mode <= 1'b0;
    wr(`LECNT_PAGE_SLOT_B, 5'h0F, 8'hA5);
    chk(slotCtrl_q, 8'h00);
    slotSel <= 5'h1F;
    repeat (2) @(posedge clk);
    chk(slotCtrl_q, 8'hA4);
    finishTest();
  end
endmodule // tb_lecnt_link_error_counters
